// ---- core/dpss_pkg.sv ----
// Purpose: shared constants and types of the parameter set sequencer
// Assumes: one clock, 32-bit AHB-Lite register bus
// Notes: set layout is eight words per set in the parameter memory
package dpss_pkg;
	// channels, sets and memory depth
	localparam int NCH = 4;
	localparam int NSETS = 32;
	localparam int WORDS = NSETS * 8;
	// word index of each entry inside a set
	localparam logic [2:0] W_OPT = 3'h0;
	localparam logic [2:0] W_SRC = 3'h1;
	localparam logic [2:0] W_CNT = 3'h2;
	localparam logic [2:0] W_DST = 3'h3;
	localparam logic [2:0] W_BSTR = 3'h4;
	localparam logic [2:0] W_LINK = 3'h5;
	localparam logic [2:0] W_CSTR = 3'h6;
	localparam logic [2:0] W_FRM = 3'h7;
	// option word flags
	localparam int OPT_FRAME_SYNC_BIT = 2;
	localparam int OPT_STATIC_BIT = 3;
	// link handling
	localparam logic [15:0] NULL_LINK = 16'hffff;
	localparam logic [15:0] LINK_MASK = 16'h3fff;
	// bus map: bit 12 selects control registers
	localparam int CTRL_REGION_BIT = 12;
	localparam logic [15:0] REG_TRIGGER = 16'h1000;
	localparam logic [15:0] REG_SECONDARY = 16'h1004;
	localparam logic [15:0] REG_MISSED = 16'h1008;
	localparam logic [15:0] REG_STATUS = 16'h100c;
	// sequencer states, gray along the usual path
	typedef enum logic [2:0] {
		DPSS_IDLE = 3'h0,
		DPSS_FETCH = 3'h1,
		DPSS_SUBMIT = 3'h3,
		DPSS_UPDATE = 3'h2,
		DPSS_LINK = 3'h6
	} dpss_state_t;
endpackage

// ---- core/dpss_sequencer.sv ----
// Purpose: per-channel parameter set sequencer submitting transfer requests
// Assumes: all inputs synchronous to MCLK; engine accepts on TR_VALID & TR_READY
// Notes: software owns the parameter memory through the AHB-Lite slave
//
// Summary of operation
// - request submitted only when byte count nonzero
// - any zero count makes null or dummy
// - array sync: arrays count minus one per request
// - array sync: at one, decrement frames, reload arrays
// - frame sync: arrays count passed, reload ignored
// - source array stride signed, both modes
// - destination array stride signed, both modes
// - source frame stride from current array start
// - destination frame stride, same current array rule
// - exhausted set reloaded from link offset
// - top two link bits ignored
// - null link writes zero set, link ones
// - null set sets missed, keeps secondary set
// - dummy when some counts zero, some not
// - dummy clears secondary, no missed, no bytes
// - each set is eight 32-bit words
// - static flag blocks updates and link
// - null and dummy still link when not static
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dpss_sequencer
	import dpss_pkg::*;
(
	// clock and reset
	input wire logic MCLK,
	input wire logic RESETN,
	// ahb-lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// synchronisation events, one pulse per event
	input wire logic [NCH-1:0] EVENT_IN,
	// transfer request to the engine
	output logic TR_VALID,
	input wire logic TR_READY,
	output logic [1:0] TR_CHANNEL,
	output logic [31:0] TR_OPTIONS,
	output logic [31:0] TR_SRC,
	output logic [31:0] TR_DST,
	output logic [15:0] TR_ARRAY_BYTES,
	output logic [15:0] TR_ARRAYS,
	output logic [15:0] TR_SRC_STRIDE,
	output logic [15:0] TR_DST_STRIDE
);
	// parameter memory, eight words per set
	logic [31:0] mem [WORDS];
	dpss_state_t state; // sequencer state
	logic [1:0] chan; // channel being serviced
	logic [31:0] snap [8]; // copy of the serviced set
	logic [NCH-1:0] pending; // events waiting for service
	logic [NCH-1:0] secondary; // secondary event flags
	logic [NCH-1:0] missed; // missed event flags
	logic dp_valid; // bus data phase in progress
	logic dp_write; // data phase is a write
	logic [15:0] dp_addr; // byte address of the data phase
	logic rd_done; // read data already captured
	logic eng_we; // engine owns the memory write port
	logic [31:0] rd_mux; // bus read data before its register
	logic [NCH-1:0] trig; // events arriving this cycle
	logic [NCH-1:0] clr_sec; // software clear of secondary
	logic [NCH-1:0] clr_mis; // software clear of missed
	logic bus_wr; // completing bus write
	logic any_pend; // some channel waits
	logic [1:0] pick; // lowest pending channel
	logic [31:0] next_set [8]; // set written back by the engine
	logic [31:0] link_set [8]; // set found at the link
	// decoded fields of the snapshot
	logic [15:0] array_byte_count, arrays_per_frame_count, frames_per_block_count, rld, link;
	logic [31:0] sbstr, dbstr, scstr, dcstr;
	logic frame_sync, is_static, is_null, is_dummy, exhausted;
	logic [4:0] link_idx; // set index of the link target

	assign array_byte_count = snap[W_CNT][15:0];
	assign arrays_per_frame_count = snap[W_CNT][31:16];
	assign frames_per_block_count = snap[W_FRM][15:0];
	assign link = snap[W_LINK][15:0];
	assign rld = snap[W_LINK][31:16];
	// strides are two's complement, sign extended to address width
	assign sbstr = {{16{snap[W_BSTR][15]}}, snap[W_BSTR][15:0]};
	assign dbstr = {{16{snap[W_BSTR][31]}}, snap[W_BSTR][31:16]};
	assign scstr = {{16{snap[W_CSTR][15]}}, snap[W_CSTR][15:0]};
	assign dcstr = {{16{snap[W_CSTR][31]}}, snap[W_CSTR][31:16]};
	assign frame_sync = snap[W_OPT][OPT_FRAME_SYNC_BIT];
	assign is_static = snap[W_OPT][OPT_STATIC_BIT];
	// classification of the set
	assign is_null = (array_byte_count == 16'h0000) && (arrays_per_frame_count == 16'h0000) && (frames_per_block_count == 16'h0000);
	assign is_dummy = !is_null && ((array_byte_count == 16'h0000) || (arrays_per_frame_count == 16'h0000) || (frames_per_block_count == 16'h0000));
	// last request of the set has gone out
	assign exhausted = frame_sync ? (frames_per_block_count == 16'h0001) : ((arrays_per_frame_count == 16'h0001) && (frames_per_block_count == 16'h0001));
	// upper two link bits dropped; only a set index survives
	assign link_idx = 5'((link & LINK_MASK) >> 5);
	assign eng_we = (state == DPSS_UPDATE) || (state == DPSS_LINK);

	// lowest numbered pending channel wins
	always_comb
	begin
		any_pend = |pending;
		pick = 2'h0;
		for (int i = NCH - 1; i >= 0; i--)
		begin
			if (pending[i])
			begin
				pick = 2'(i);
			end
		end
	end

	// updated set for the next event
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			next_set[i] = snap[i];
		end
		if (frame_sync)
		begin
			// frame sync: engine walks the arrays, only frames counted here
			next_set[W_SRC] = snap[W_SRC] + scstr;
			next_set[W_DST] = snap[W_DST] + dcstr;
			next_set[W_FRM][15:0] = frames_per_block_count - 16'h0001;
		end
		else if (arrays_per_frame_count > 16'h0001)
		begin
			// next array of the frame
			next_set[W_SRC] = snap[W_SRC] + sbstr;
			next_set[W_DST] = snap[W_DST] + dbstr;
			next_set[W_CNT][31:16] = arrays_per_frame_count - 16'h0001;
		end
		else
		begin
			// last array done: step frame from the last array, reload arrays
			next_set[W_SRC] = snap[W_SRC] + scstr;
			next_set[W_DST] = snap[W_DST] + dcstr;
			next_set[W_CNT][31:16] = rld;
			next_set[W_FRM][15:0] = frames_per_block_count - 16'h0001;
		end
	end

	// set copied in by linking, or the null set
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			link_set[i] = (link == NULL_LINK) ? 32'h0000_0000 : mem[{link_idx, 3'(i)}];
		end
		if (link == NULL_LINK)
		begin
			link_set[W_LINK] = {16'h0000, NULL_LINK};
		end
	end

	// sequencer state machine
	always_ff @(posedge MCLK)
	begin
		if (!RESETN)
			state <= DPSS_IDLE;
		else
		begin
			unique case (state)
				DPSS_IDLE:
					if (any_pend)
						state <= DPSS_FETCH;
				// null and dummy move nothing; only a link may follow
				DPSS_FETCH:
					if (is_null || is_dummy)
						state <= is_static ? DPSS_IDLE : DPSS_LINK;
					else
						state <= DPSS_SUBMIT;
				// static sets are never touched after submission
				DPSS_SUBMIT:
					if (TR_READY && is_static)
						state <= DPSS_IDLE;
					else if (TR_READY)
						state <= exhausted ? DPSS_LINK : DPSS_UPDATE;
				DPSS_UPDATE, DPSS_LINK:
					state <= DPSS_IDLE;
				default:
					state <= DPSS_IDLE;
			endcase
		end
	end

	// channel choice and snapshot together, so fetch decides on the new set
	always_ff @(posedge MCLK)
	begin
		if (!RESETN)
		begin
			chan <= 2'h0;
			for (int i = 0; i < 8; i++)
				snap[i] <= 32'h0000_0000;
		end
		else if (state == DPSS_IDLE && any_pend)
		begin
			chan <= pick;
			for (int i = 0; i < 8; i++)
				snap[i] <= mem[{3'h0, pick, 3'(i)}];
		end
	end

	// memory write port; the bus is stalled while the engine writes
	always_ff @(posedge MCLK)
	begin
		if (eng_we)
		begin
			for (int i = 0; i < 8; i++)
			begin
				mem[{3'h0, chan, 3'(i)}] <= (state == DPSS_LINK) ? link_set[i] : next_set[i];
			end
		end
		else if (bus_wr && !dp_addr[CTRL_REGION_BIT])
		begin
			mem[dp_addr[9:2]] <= HWDATA;
		end
	end

	// transfer request register, loaded when a normal set is fetched
	always_ff @(posedge MCLK)
	begin
		if (!RESETN)
		begin
			TR_VALID <= 1'b0;
			TR_CHANNEL <= 2'h0;
			TR_OPTIONS <= 32'h0000_0000;
			TR_SRC <= 32'h0000_0000;
			TR_DST <= 32'h0000_0000;
			TR_ARRAY_BYTES <= 16'h0000;
			TR_ARRAYS <= 16'h0000;
			TR_SRC_STRIDE <= 16'h0000;
			TR_DST_STRIDE <= 16'h0000;
		end
		else if (state == DPSS_FETCH && !is_null && !is_dummy)
		begin
			TR_VALID <= 1'b1;
			TR_CHANNEL <= chan;
			TR_OPTIONS <= snap[W_OPT];
			TR_SRC <= snap[W_SRC];
			TR_DST <= snap[W_DST];
			TR_ARRAY_BYTES <= array_byte_count;
			// array sync sends one array; frame sync hands the count over
			TR_ARRAYS <= frame_sync ? arrays_per_frame_count : 16'h0001;
			TR_SRC_STRIDE <= snap[W_BSTR][15:0];
			TR_DST_STRIDE <= snap[W_BSTR][31:16];
		end
		else if (state == DPSS_SUBMIT && TR_READY)
		begin
			TR_VALID <= 1'b0;
		end
	end

	// events: hardware pulses or software trigger writes
	assign bus_wr = dp_valid && dp_write && HREADYOUT;
	assign trig = EVENT_IN | ((bus_wr && dp_addr == REG_TRIGGER) ? HWDATA[NCH-1:0] : '0);
	assign clr_sec = (bus_wr && dp_addr == REG_SECONDARY) ? HWDATA[NCH-1:0] : '0;
	assign clr_mis = (bus_wr && dp_addr == REG_MISSED) ? HWDATA[NCH-1:0] : '0;

	// pending: an event taken while secondary is clear
	always_ff @(posedge MCLK)
	begin
		if (!RESETN)
			pending <= '0;
		else
		begin
			for (int i = 0; i < NCH; i++)
			begin
				if (trig[i] && !secondary[i])
					pending[i] <= 1'b1;
				else if (state == DPSS_IDLE && any_pend && pick == 2'(i))
					pending[i] <= 1'b0;
			end
		end
	end

	// secondary flags: set by events, cleared on non-null service or by software
	always_ff @(posedge MCLK)
	begin
		if (!RESETN)
			secondary <= '0;
		else
		begin
			for (int i = 0; i < NCH; i++)
			begin
				if (trig[i])
				begin
					// set wins over any clear in the same cycle
					secondary[i] <= 1'b1;
				end
				else if (state == DPSS_FETCH && chan == 2'(i) && !is_null)
					secondary[i] <= 1'b0;
				else if (clr_sec[i])
					secondary[i] <= 1'b0;
			end
		end
	end

	// missed flags: null service or event while secondary stays set
	always_ff @(posedge MCLK)
	begin
		if (!RESETN)
			missed <= '0;
		else
		begin
			for (int i = 0; i < NCH; i++)
			begin
				if ((state == DPSS_FETCH && chan == 2'(i) && is_null) || (trig[i] && secondary[i]))
				begin
					// null leaves secondary set, so later events land here
					missed[i] <= 1'b1;
				end
				else if (clr_mis[i])
					missed[i] <= 1'b0;
			end
		end
	end

	// ahb data phase tracking
	always_ff @(posedge MCLK)
	begin
		if (!RESETN)
		begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= 16'h0000;
		end
		else if (HREADY)
		begin
			dp_valid <= HSEL && HTRANS[1];
			dp_write <= HWRITE;
			dp_addr <= HADDR[15:0];
		end
	end

	// read mux; unmapped control addresses read as zero, other addresses alias the memory
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (!dp_addr[CTRL_REGION_BIT])
		begin
			rd_mux = mem[dp_addr[9:2]];
		end
		else if (dp_addr == REG_SECONDARY)
		begin
			rd_mux[NCH-1:0] = secondary;
		end
		else if (dp_addr == REG_MISSED)
		begin
			rd_mux[NCH-1:0] = missed;
		end
		else if (dp_addr == REG_STATUS)
		begin
			rd_mux = {24'h000000, chan, state, 2'h0, (state != DPSS_IDLE)};
		end
	end

	// reads take one wait state so read data comes from a flip-flop
	always_ff @(posedge MCLK)
	begin
		if (!RESETN)
		begin
			rd_done <= 1'b0;
			HRDATA <= 32'h0000_0000;
		end
		else if (dp_valid && !dp_write && !rd_done && !eng_we)
		begin
			rd_done <= 1'b1;
			HRDATA <= rd_mux;
		end
		else if (HREADYOUT)
		begin
			rd_done <= 1'b0;
		end
	end

	// stall for the read wait state and while the engine writes memory
	assign HREADYOUT = !(dp_valid && ((!dp_write && !rd_done) || eng_we));
	assign HRESP = 1'b0;
endmodule
`default_nettype wire

// ---- sim/dpss_engine_model.sv ----
// Purpose: stand-in for the transfer engine behind the sequencer
// Assumes: request held until accepted
// Notes: slow mode stalls four cycles
`timescale 1ns/1ps
`default_nettype none
module dpss_engine_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// request handshake
	input wire logic req_valid,
	input wire logic slow,
	output logic req_ready
);
	logic [1:0] wait_cnt; // cycles spent on this request
	// accept one cycle after valid, or four when slow; ready drops after each take
	always_ff @(posedge clk)
	begin
		if (!rst_n || !req_valid || req_ready)
		begin
			wait_cnt <= 2'h0;
			req_ready <= 1'b0;
		end
		else
		begin
			wait_cnt <= wait_cnt + 2'h1;
			req_ready <= !slow || (wait_cnt == 2'h3);
		end
	end
endmodule
`default_nettype wire

// ---- sim/dpss_seq_props.sv ----
// Purpose: port checker of the parameter set sequencer
// Assumes: one clock, reset low is the disable
// Notes: bound to dpss_sequencer below
`timescale 1ns/1ps
`default_nettype none
module dpss_seq_props
	import dpss_pkg::*;
(
	// clock, reset and bus
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic HSEL,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	// request side
	input wire logic TR_VALID,
	input wire logic TR_READY,
	input wire logic [31:0] TR_OPTIONS,
	input wire logic [31:0] TR_SRC,
	input wire logic [15:0] TR_ARRAY_BYTES,
	input wire logic [15:0] TR_ARRAYS
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RESETN);
	logic rd_take; // read address phase taken
	assign rd_take = HSEL && HTRANS[1] && HREADY && !HWRITE;
	a_bytes_nonzero: assert property (TR_VALID |-> TR_ARRAY_BYTES != 16'h0)
		else $error("request with zero bytes");
	a_arrays_nonzero: assert property (TR_VALID |-> TR_ARRAYS != 16'h0)
		else $error("request with zero arrays");
	a_async_single: assert property (TR_VALID && !TR_OPTIONS[OPT_FRAME_SYNC_BIT] |-> TR_ARRAYS == 16'h1)
		else $error("array sync request not single");
	a_req_hold: assert property (TR_VALID && !TR_READY |=> TR_VALID && $stable(TR_SRC) && $stable(TR_ARRAYS))
		else $error("request changed before accept");
	a_req_release: assert property (TR_VALID && TR_READY |=> !TR_VALID [*2])
		else $error("request not released");
	a_read_wait: assert property (rd_take |=> !HREADYOUT)
		else $error("read without wait state");
	a_ready_bound: assert property (!HREADYOUT |-> ##[1:3] HREADYOUT)
		else $error("bus wait too long");
	a_resp_okay: assert property (HRESP == 1'b0)
		else $error("bus error response");
	c_fsync: cover property (TR_VALID && TR_READY && TR_OPTIONS[OPT_FRAME_SYNC_BIT]);
	c_stall: cover property (TR_VALID && !TR_READY ##1 TR_VALID);
	c_read: cover property (rd_take);
endmodule
bind dpss_sequencer dpss_seq_props u_props (.MCLK(MCLK), .RESETN(RESETN), .HSEL(HSEL), .HTRANS(HTRANS),
	.HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TR_VALID(TR_VALID),
	.TR_READY(TR_READY), .TR_OPTIONS(TR_OPTIONS), .TR_SRC(TR_SRC), .TR_ARRAY_BYTES(TR_ARRAY_BYTES),
	.TR_ARRAYS(TR_ARRAYS));
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench of the parameter set sequencer
// Assumes: sets written whole before any trigger
// Notes: channel 0 fires on its pin, others by register
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin errors++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_top
	import dpss_pkg::*;
;
	logic mclk = 1'b0; // 100 MHz
	logic rst_n = 1'b0; // held low for 8 cycles
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic slow = 1'b0; // engine stall select
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [NCH-1:0] ev = '0;
	logic [31:0] hrdata, tr_src, tr_dst, t_src, t_dst;
	logic hrdy, hresp, tr_valid, tr_ready;
	logic [1:0] tr_ch, t_ch;
	logic [15:0] tr_bytes, tr_arr, tr_ss, tr_ds, t_arr, t_ss, t_ds, t_bytes;
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int tr_count = 0;
	typedef logic [31:0] dpss_words_t [8];
	dpss_sequencer u_dut (.MCLK(mclk), .RESETN(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy),
		.HRESP(hresp), .EVENT_IN(ev), .TR_VALID(tr_valid), .TR_READY(tr_ready), .TR_CHANNEL(tr_ch),
		.TR_OPTIONS(), .TR_SRC(tr_src), .TR_DST(tr_dst), .TR_ARRAY_BYTES(tr_bytes), .TR_ARRAYS(tr_arr),
		.TR_SRC_STRIDE(tr_ss), .TR_DST_STRIDE(tr_ds));
	dpss_engine_model u_eng (.clk(mclk), .rst_n(rst_n), .req_valid(tr_valid), .slow(slow),
		.req_ready(tr_ready));
	always #5 mclk = ~mclk;
	// log accepted requests; cut a hang short
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (tr_valid && tr_ready)
		begin
			tr_count <= tr_count + 1;
			t_src <= tr_src;
			t_ch <= tr_ch;
			t_bytes <= tr_bytes;
			t_dst <= tr_dst;
			t_arr <= tr_arr;
			t_ss <= tr_ss;
			t_ds <= tr_ds;
		end
		if (cycles == 5000)
		begin
			errors++;
			finish_test;
		end
	end
	task automatic finish_test;
		if (errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// one single word transfer; ready looked at just before each edge
	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {16'h0, a};
		hwrite <= w;
		do @(negedge mclk); while (!hrdy);
		@(posedge mclk);
		htrans <= 2'h0;
		hwdata <= d;
		do @(negedge mclk); while (!hrdy);
		q = hrdata;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rc(input logic [15:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		`CHK($sformatf("word %h", a), e, q)
	endtask
	task automatic wset(input int s, input dpss_words_t w);
		for (int i = 0; i < 8; i++)
			wr(16'(s * 32 + i * 4), w[i]);
	endtask
	// fire a channel, allow service to finish, count new requests
	task automatic trig(input int c, input int k);
		int n;
		n = tr_count;
		if (c == 0)
		begin
			ev <= 4'h1;
			@(posedge mclk);
			ev <= 4'h0;
		end
		else
			wr(REG_TRIGGER, 32'h1 << c);
		repeat (14) @(posedge mclk);
		`CHK("requests", n + k, tr_count)
	endtask
	task automatic req(input int c, input logic [31:0] s, input logic [31:0] d, input logic [15:0] a);
		trig(c, 1);
		`CHK("chan", 2'(c), t_ch)
		`CHK("src", s, t_src)
		`CHK("dst", d, t_dst)
		`CHK("arrays", a, t_arr)
	endtask
	initial
	begin
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rc(REG_MISSED, 32'h0);
		rc(16'h1010, 32'h0);
		// positive and negative strides, counts in range, aligned links
		wset(0, '{32'h0, 32'h100, 32'h10004, 32'h200, 32'hffff0003, 32'h24040, 32'h200010, 32'h2});
		wset(1, '{32'h4, 32'h500, 32'h30008, 32'h600, 32'h100004, 32'h9ffff, 32'h1000040, 32'h2});
		wset(2, '{32'h8, 32'h300, 32'h10002, 32'h400, 32'h0, 32'hffff, 32'h10, 32'h2});
		wset(3, '{32'h0, 32'h700, 32'h10000, 32'h800, 32'h0, 32'h40, 32'h0, 32'h1});
		req(0, 32'h100, 32'h200, 16'h1);
		`CHK("bytes", 16'h4, t_bytes)
		rc(16'h4, 32'h110);
		rc(16'hc, 32'h220);
		rc(16'h8, 32'h20004);
		rc(16'h1c, 32'h1);
		req(0, 32'h110, 32'h220, 16'h1);
		rc(16'h4, 32'h113);
		rc(16'hc, 32'h21f);
		rc(16'h8, 32'h10004);
		req(0, 32'h113, 32'h21f, 16'h1);
		rc(16'h0, 32'h8);
		req(0, 32'h300, 32'h400, 16'h1);
		rc(16'h4, 32'h300);
		rc(16'h1c, 32'h2);
		slow <= 1'b1;
		req(1, 32'h500, 32'h600, 16'h3);
		rc(REG_STATUS, 32'h40);
		`CHK("src stride", 16'h4, t_ss)
		`CHK("dst stride", 16'h10, t_ds)
		rc(16'h24, 32'h540);
		rc(16'h2c, 32'h700);
		rc(16'h28, 32'h30008);
		req(1, 32'h540, 32'h700, 16'h3);
		rc(16'h24, 32'h0);
		rc(16'h34, 32'hffff);
		trig(1, 0);
		rc(REG_MISSED, 32'h2);
		rc(REG_SECONDARY, 32'h2);
		wset(1, '{32'h8, 32'h900, 32'h10001, 32'ha00, 32'h0, 32'hffff, 32'h0, 32'h1});
		trig(1, 0);
		wr(REG_SECONDARY, 32'h2);
		wr(REG_MISSED, 32'h2);
		req(1, 32'h900, 32'ha00, 16'h1);
		trig(3, 0);
		rc(REG_MISSED, 32'h0);
		rc(REG_SECONDARY, 32'h0);
		rc(16'h64, 32'h300);
		finish_test;
	end
endmodule
`default_nettype wire
